/* File: rtl/fepc_cfg.svh */
// Constants of the flash erase/program controller: register addresses,
// field positions, keys, op codes, region bounds and timing.
// Assumes inclusion by bare name from both ends, the checker and the bench.
`ifndef FEPC_CFG_SVH
`define FEPC_CFG_SVH

// Register addresses
`define FEPC_REG_STATUS 32'h4002_0000
`define FEPC_REG_OPSEL_A 32'h4002_0004
`define FEPC_REG_OPSEL_B 32'h4002_0008
`define FEPC_REG_ERASE_TYPE 32'h4002_000C
`define FEPC_REG_CHIP_TIM 32'h4002_0010
`define FEPC_REG_SECT_TIM 32'h4002_0014
`define FEPC_REG_PROG_TIM 32'h4002_001C
`define FEPC_REG_GUARD 32'h4002_0020
`define FEPC_REG_RANGE 32'h4002_0210
`define FEPC_REG_PAGE 20'h4_0020

// Field positions
`define FEPC_ST_DONE 0
`define FEPC_ST_VERR 2
`define FEPC_ET_VERIFY 4
`define FEPC_ET_CHIP 3
`define FEPC_ERASE_SEL 31
`define FEPC_PROG_SEL 15
`define FEPC_SETUP_SEL 31
`define FEPC_SETUP_LSB 16

// Keys and operation codes
`define FEPC_KEY_GUARD 7'h78
`define FEPC_KEY_RANGE 24'h5A_A5F1
`define FEPC_OP_ERASE_A 8'h55
`define FEPC_OP_ERASE_B 8'hAA
`define FEPC_OP_WRITE_A 8'hAA
`define FEPC_OP_WRITE_B 8'h55
`define FEPC_OP_READ 8'h00

// Flash regions
`define FEPC_CODE_END 32'h0007_FFFF
`define FEPC_DATA_BASE 32'h0050_1000
`define FEPC_DATA_END 32'h0050_5FFF

// Timing
`define FEPC_CLK_MHZ 10
`define FEPC_FETCH_MAX_MHZ 32
`define FEPC_T_CHIP_MS 20
`define FEPC_T_SECT_MS 4
`define FEPC_T_PROG_US 24
`define FEPC_T_SETUP_US 5
`define FEPC_CHIP_SHIFT 11
`define FEPC_SECT_SHIFT 8
`define FEPC_PROG_SHIFT 2

// Host-side command registers
`define FEPC_H_ADDR 32'h0000_0000
`define FEPC_H_WDATA 32'h0000_0004
`define FEPC_H_CTRL 32'h0000_0008
`define FEPC_H_STATUS 32'h0000_000C
`define FEPC_H_RDATA 32'h0000_0010
`define FEPC_H_SLEEP 32'h0000_0014
`define FEPC_RESP_OK 2'h0
`define FEPC_RESP_ERR 2'h2

`endif

/* File: rtl/fepc_dev.sv */
// Flash erase/program controller: registers, protection, op sequencing.
// Assumes a single 10 MHz clock and a flash array answering verify
// errors combinationally while the check strobe is high.
//
// Functional notes
// (RULE1) Guard register: unlock bit 0, key 7:1
// (RULE2) Op-select writes only while unlocked
// (RULE3) Unlock bit changes only with key 78h
// (RULE4) Op pair 55/AA erase, AA/55 write
// (RULE5) Erase type bits 4:3 pick sector/verify/chip
// (RULE6) Chip erase: code region only, no verify
// (RULE7) Done flag W1C; blocks next operation
// (RULE8) Verify error flag set on check fail
// (RULE9) Timing select bit: hardware or software count
// (RULE10) Chip erase lasts count times 2048 clocks
// (RULE11) Sector erase lasts count times 256 clocks
// (RULE12) Word write lasts count times 4 clocks
// (RULE13) Setup lasts setup count clocks
// (RULE14) Range field writable only with key 5AA5F1
// (RULE15) Range code protects zero up to bound
// (RULE16) Software sector erase sequence
// (RULE17) Chip erase starts on code region write
// (RULE18) Word program takes next bus write
// (RULE19) One wait state above 32 MHz; code inserts one wait state at 32 MHz or below and two above
// (RULE20) Flash accesses stall during an operation
// (RULE21) Deep sleep waits for operation end
// (RULE22) Hardware timing advised at low clocks
// (RULE23) Protected or read-mode writes start nothing
`timescale 1ns/1ps
`include "fepc_cfg.svh"
module fepc_dev
  import fepc_pkg::*;
#(
  parameter int CLK_MHZ = `FEPC_CLK_MHZ,
  parameter int HW_CHIP_CYC = `FEPC_T_CHIP_MS * 1000 * `FEPC_CLK_MHZ,
  parameter int HW_SECT_CYC = `FEPC_T_SECT_MS * 1000 * `FEPC_CLK_MHZ
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Processor bus
  fepc_if.dev bus,
  // Flash array
  output logic fa_erase_o,
  output logic fa_chip_o,
  output logic fa_prog_o,
  output logic fa_setup_o,
  output logic fa_check_o,
  output logic [31:0] fa_addr_o,
  output logic [31:0] fa_wdata_o,
  input wire logic [31:0] fa_rdata_i,
  input wire logic fa_verr_i
);

  localparam int HW_PROG_CYC = `FEPC_T_PROG_US * `FEPC_CLK_MHZ;
  localparam int HW_SETUP_CYC = `FEPC_T_SETUP_US * `FEPC_CLK_MHZ;
  localparam logic [1:0] WAIT_N = (CLK_MHZ > `FEPC_FETCH_MAX_MHZ) ? 2'h2 : 2'h1;

  fepc_dev_s st_ff;
  fepc_dev_s nxt_st;

  // Top of the protected range, valid flag in bit 32
  function automatic logic [32:0] prot_bound(input logic [3:0] code);
    logic [32:0] b;
    b = '0;
    case (code)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5: b = {1'b1, (32'h0000_1000 << (code - 4'h1)) - 32'h0000_0001};
      4'h6: b = {1'b1, 32'h0001_FFFF};
      4'h7: b = {1'b1, 32'h0003_FFFF};
      4'h8: b = {1'b1, 32'h0005_FFFF};
      4'h9: b = {1'b1, 32'h0007_FFFF};
      default: b = '0;
    endcase
    return b;
  endfunction

  logic is_code;
  logic is_data;
  logic is_flash;
  logic is_reg;
  logic busy;
  logic [32:0] bound;
  logic mode_erase;
  logic mode_write;
  logic [31:0] reg_rd;

  // Address decode and mode
  assign is_code = bus.addr <= `FEPC_CODE_END;
  assign is_data = (bus.addr >= `FEPC_DATA_BASE) && (bus.addr <= `FEPC_DATA_END);
  assign is_flash = is_code || is_data;
  assign is_reg = bus.addr[31:12] == `FEPC_REG_PAGE;
  assign busy = st_ff.ph != ST_IDLE;
  assign bound = prot_bound(st_ff.rp); // RULE15
  assign mode_erase = (st_ff.opa == `FEPC_OP_ERASE_A) && (st_ff.opb == `FEPC_OP_ERASE_B); // RULE4
  assign mode_write = (st_ff.opa == `FEPC_OP_WRITE_A) && (st_ff.opb == `FEPC_OP_WRITE_B); // RULE4

  // Register read mux; unmapped reads zero
  always_comb begin
    case (bus.addr)
      `FEPC_REG_STATUS: reg_rd = 32'({st_ff.verr, 1'b0, st_ff.done});
      `FEPC_REG_OPSEL_A: reg_rd = 32'(st_ff.opa);
      `FEPC_REG_OPSEL_B: reg_rd = 32'(st_ff.opb);
      `FEPC_REG_ERASE_TYPE: reg_rd = 32'({st_ff.etype, 3'h0});
      `FEPC_REG_CHIP_TIM: reg_rd = {st_ff.csel, 31'(st_ff.ccnt)};
      `FEPC_REG_SECT_TIM: reg_rd = {st_ff.esel, 31'(st_ff.ecnt)};
      `FEPC_REG_PROG_TIM: reg_rd = {st_ff.ssel, 6'h00, st_ff.scnt, st_ff.psel, 6'h00, st_ff.pcnt};
      `FEPC_REG_GUARD: reg_rd = 32'(st_ff.unlock);
      `FEPC_REG_RANGE: reg_rd = 32'(st_ff.rp);
      default: reg_rd = '0;
    endcase
  end

  // Next state: bus slave, register writes, sequencer
  always_comb begin
    logic acc;
    logic prot;
    logic [21:0] dur;
    acc = 1'b0;
    prot = 1'b0;
    dur = '0;
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.sleep_ok = 1'b0;
    acc = bus.req && !st_ff.ack;

    // Sequencer
    case (st_ff.ph)
      ST_SETUP: begin
        if (st_ff.cnt <= 22'h1) begin
          nxt_st.ph = ST_PULSE;
          dur = st_ff.psel ? {11'h000, st_ff.pcnt, 2'h0} : 22'(HW_PROG_CYC); // RULE9 RULE12
          nxt_st.cnt = dur;
        end else begin
          nxt_st.cnt = st_ff.cnt - 22'h1;
        end
      end
      ST_PULSE: begin
        if (st_ff.cnt <= 22'h1) begin
          if (st_ff.kind == K_SECT && st_ff.verify) begin
            nxt_st.ph = ST_VERIFY; // RULE5
          end else begin
            nxt_st.ph = ST_IDLE;
            nxt_st.done = 1'b1; // RULE7
          end
        end else begin
          nxt_st.cnt = st_ff.cnt - 22'h1;
        end
      end
      ST_VERIFY: begin
        nxt_st.ph = ST_IDLE;
        nxt_st.done = 1'b1; // RULE7
        if (fa_verr_i) begin
          nxt_st.verr = 1'b1; // RULE8
        end
      end
      default: nxt_st.ph = ST_IDLE;
    endcase

    // Bus access
    if (acc) begin
      if (is_flash && busy) begin
        nxt_st.wt = 2'h0; // RULE20
      end else if (is_flash && st_ff.wt < WAIT_N) begin
        nxt_st.wt = st_ff.wt + 2'h1; // RULE19
        nxt_st.addr = bus.addr;
      end else begin
        nxt_st.wt = 2'h0;
        nxt_st.ack = 1'b1;
        nxt_st.rdata = is_reg ? reg_rd : (is_flash ? fa_rdata_i : '0);
        if (bus.we && is_reg) begin
          case (bus.addr)
            `FEPC_REG_STATUS: begin
              // Hardware set above wins over this clear
              if (bus.wdata[`FEPC_ST_DONE] && !(nxt_st.done && !st_ff.done)) begin
                nxt_st.done = 1'b0; // RULE7
              end
              if (bus.wdata[`FEPC_ST_VERR] && !(nxt_st.verr && !st_ff.verr)) begin
                nxt_st.verr = 1'b0; // RULE8
              end
            end
            `FEPC_REG_OPSEL_A: if (st_ff.unlock) nxt_st.opa = bus.wdata[7:0]; // RULE2
            `FEPC_REG_OPSEL_B: if (st_ff.unlock) nxt_st.opb = bus.wdata[7:0]; // RULE2
            `FEPC_REG_ERASE_TYPE: begin
              nxt_st.etype = bus.wdata[`FEPC_ET_VERIFY:`FEPC_ET_CHIP]; // RULE5
            end
            `FEPC_REG_CHIP_TIM: begin
              nxt_st.csel = bus.wdata[`FEPC_ERASE_SEL];
              nxt_st.ccnt = bus.wdata[9:0];
            end
            `FEPC_REG_SECT_TIM: begin
              nxt_st.esel = bus.wdata[`FEPC_ERASE_SEL];
              nxt_st.ecnt = bus.wdata[9:0];
            end
            `FEPC_REG_PROG_TIM: begin
              nxt_st.psel = bus.wdata[`FEPC_PROG_SEL];
              nxt_st.pcnt = bus.wdata[8:0];
              nxt_st.ssel = bus.wdata[`FEPC_SETUP_SEL];
              nxt_st.scnt = bus.wdata[`FEPC_SETUP_LSB +: 9];
            end
            `FEPC_REG_GUARD: begin
              if (bus.wdata[7:1] == `FEPC_KEY_GUARD) begin
                nxt_st.unlock = bus.wdata[0]; // RULE1 RULE3
              end
            end
            `FEPC_REG_RANGE: begin
              if (bus.wdata[31:8] == `FEPC_KEY_RANGE) begin
                nxt_st.rp = bus.wdata[3:0]; // RULE14
              end
            end
            default: nxt_st.rp = st_ff.rp;
          endcase
        end else if (bus.we && is_flash && !st_ff.done) begin
          // Operation start; done must be clear first
          prot = is_code && bound[32] && (bus.addr <= bound[31:0]); // RULE15 RULE23
          nxt_st.wdata = bus.wdata;
          nxt_st.addr = bus.addr;
          if (mode_write && !prot) begin
            nxt_st.kind = K_PROG; // RULE18
            nxt_st.ph = ST_SETUP;
            dur = st_ff.ssel ? {13'h0000, st_ff.scnt} : 22'(HW_SETUP_CYC); // RULE9 RULE13
            nxt_st.cnt = dur;
          end else if (mode_erase && st_ff.etype == 2'h1 && is_code && !bound[32]) begin
            nxt_st.kind = K_CHIP; // RULE6 RULE17
            nxt_st.verify = 1'b0;
            nxt_st.ph = ST_PULSE;
            dur = st_ff.csel ? {st_ff.ccnt, 12'h000} >> 1 : 22'(HW_CHIP_CYC); // RULE10
            nxt_st.cnt = dur;
          end else if (mode_erase && !st_ff.etype[0] && !prot) begin
            nxt_st.kind = K_SECT; // RULE16
            nxt_st.verify = st_ff.etype[1];
            nxt_st.ph = ST_PULSE;
            dur = st_ff.esel ? {4'h0, st_ff.ecnt, 8'h00} : 22'(HW_SECT_CYC); // RULE11
            nxt_st.cnt = dur;
          end else begin
            nxt_st.kind = st_ff.kind; // RULE23
          end
        end
      end
    end else begin
      nxt_st.wt = 2'h0;
    end

    // Array strobes follow the next phase
    nxt_st.fa_setup = nxt_st.ph == ST_SETUP;
    nxt_st.fa_prog = nxt_st.ph == ST_PULSE && nxt_st.kind == K_PROG;
    nxt_st.fa_erase = nxt_st.ph == ST_PULSE && nxt_st.kind != K_PROG;
    nxt_st.fa_chip = nxt_st.ph == ST_PULSE && nxt_st.kind == K_CHIP; // RULE6
    nxt_st.fa_check = nxt_st.ph == ST_VERIFY;
    nxt_st.sleep_ok = bus.sleep_req && nxt_st.ph == ST_IDLE; // RULE21
  end

  // State register
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign bus.ack = st_ff.ack;
  assign bus.rdata = st_ff.rdata;
  assign bus.sleep_ok = st_ff.sleep_ok;
  assign fa_erase_o = st_ff.fa_erase;
  assign fa_chip_o = st_ff.fa_chip;
  assign fa_prog_o = st_ff.fa_prog;
  assign fa_setup_o = st_ff.fa_setup;
  assign fa_check_o = st_ff.fa_check;
  assign fa_addr_o = st_ff.addr;
  assign fa_wdata_o = st_ff.wdata;

endmodule // fepc_dev

/* File: rtl/fepc_host.sv */
// Processor end: takes bus commands from software over AXI4-Lite and
// drives single reads and writes toward the flash controller.
// Assumes the same clock as the controller and an AXI4-Lite master.
`timescale 1ns/1ps
`include "fepc_cfg.svh"
module fepc_host
  import fepc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Controller bus
  fepc_if.host bus
);

  fepc_host_s st_ff;
  fepc_host_s nxt_st;

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Channel readiness
  assign s_axi_awready = !st_ff.aw_have && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_have && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;

  // Next state: AXI slave and command engine
  always_comb begin
    logic ack_seen;
    ack_seen = 1'b0;
    nxt_st = st_ff;

    // Bus command completes on acknowledge
    ack_seen = st_ff.req && bus.ack;
    if (ack_seen) begin
      nxt_st.req = 1'b0;
      nxt_st.busy = 1'b0;
      nxt_st.done = 1'b1;
      nxt_st.got = bus.rdata;
    end

    // Address and data captured in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_have = 1'b1;
      nxt_st.wdat = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Register write once both halves are in
    if (st_ff.aw_have && st_ff.w_have) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `FEPC_RESP_OK;
      case ({st_ff.awaddr[31:2], 2'h0})
        `FEPC_H_ADDR: nxt_st.cmd_addr = merge(st_ff.cmd_addr, st_ff.wdat, st_ff.wstrb);
        `FEPC_H_WDATA: nxt_st.cmd_wdata = merge(st_ff.cmd_wdata, st_ff.wdat, st_ff.wstrb);
        `FEPC_H_CTRL: begin
          if (st_ff.wstrb[0] && st_ff.wdat[0] && !st_ff.busy) begin
            nxt_st.busy = 1'b1;
            nxt_st.req = 1'b1;
            nxt_st.we = st_ff.wdat[1];
            nxt_st.fetch = st_ff.wdat[2];
          end
        end
        `FEPC_H_STATUS: begin
          if (st_ff.wstrb[0] && st_ff.wdat[1] && !ack_seen) nxt_st.done = 1'b0;
        end
        `FEPC_H_RDATA: nxt_st.bresp = `FEPC_RESP_OK;
        `FEPC_H_SLEEP: if (st_ff.wstrb[0]) nxt_st.sleep_req = st_ff.wdat[0];
        default: nxt_st.bresp = `FEPC_RESP_ERR;
      endcase
    end

    // Register read
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `FEPC_RESP_OK;
      case ({s_axi_araddr[31:2], 2'h0})
        `FEPC_H_ADDR: nxt_st.rdat = st_ff.cmd_addr;
        `FEPC_H_WDATA: nxt_st.rdat = st_ff.cmd_wdata;
        `FEPC_H_CTRL: nxt_st.rdat = 32'({st_ff.fetch, st_ff.we, st_ff.busy});
        `FEPC_H_STATUS: nxt_st.rdat = 32'({bus.sleep_ok, st_ff.done, st_ff.busy});
        `FEPC_H_RDATA: nxt_st.rdat = st_ff.got;
        `FEPC_H_SLEEP: nxt_st.rdat = 32'(st_ff.sleep_req);
        default: begin
          nxt_st.rdat = '0;
          nxt_st.rresp = `FEPC_RESP_ERR;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_rdata = st_ff.rdat;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign bus.req = st_ff.req;
  assign bus.we = st_ff.we;
  assign bus.fetch = st_ff.fetch;
  assign bus.addr = st_ff.cmd_addr;
  assign bus.wdata = st_ff.cmd_wdata;
  assign bus.sleep_req = st_ff.sleep_req;

endmodule // fepc_host

/* File: rtl/fepc_if.sv */
// Processor-side bus between the core end and the flash controller.
// Assumes one clock shared by both ends; the bench joins them.
`timescale 1ns/1ps
interface fepc_if;
  logic req;
  logic we;
  logic fetch;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  logic sleep_req;
  logic sleep_ok;

  // Flash controller end
  modport dev (
    input req, we, fetch, addr, wdata, sleep_req,
    output rdata, ack, sleep_ok
  );

  // Processor end
  modport host (
    output req, we, fetch, addr, wdata, sleep_req,
    input rdata, ack, sleep_ok
  );
endinterface

/* File: rtl/fepc_pkg.sv */
// Types shared by both ends of the flash erase/program controller.
// Assumes fepc_cfg.svh for all numeric constants.
package fepc_pkg;

  // Sequencer phase
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_VERIFY} fepc_phase_e;

  // Operation kind
  typedef enum logic [1:0] {K_SECT, K_CHIP, K_PROG} fepc_kind_e;

  // Device-end state
  typedef struct packed {
    logic unlock;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [1:0] etype;
    logic csel;
    logic [9:0] ccnt;
    logic esel;
    logic [9:0] ecnt;
    logic psel;
    logic [8:0] pcnt;
    logic ssel;
    logic [8:0] scnt;
    logic [3:0] rp;
    logic done;
    logic verr;
    fepc_phase_e ph;
    fepc_kind_e kind;
    logic verify;
    logic [21:0] cnt;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] wt;
    logic ack;
    logic [31:0] rdata;
    logic sleep_ok;
    logic fa_erase;
    logic fa_chip;
    logic fa_prog;
    logic fa_setup;
    logic fa_check;
  } fepc_dev_s;

  // Host-end state
  typedef struct packed {
    logic aw_have;
    logic [31:0] awaddr;
    logic w_have;
    logic [31:0] wdat;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdat;
    logic [31:0] cmd_addr;
    logic [31:0] cmd_wdata;
    logic busy;
    logic done;
    logic [31:0] got;
    logic req;
    logic we;
    logic fetch;
    logic sleep_req;
  } fepc_host_s;

endpackage

/* File: tb/fepc_assertions.sv */
// Checker of the controller bus and the flash strobes between both ends.
// Assumes instantiation beside the interface in the bench top, one clock.
`timescale 1ns/1ps
`include "fepc_cfg.svh"
module fepc_assertions
  import fepc_pkg::*;
(
  // Clock and reset
  input logic mclk_i,
  input logic arst_n_i,
  // Controller bus
  input logic req,
  input logic [31:0] addr,
  input logic ack,
  input logic sleep_ok,
  // Flash strobes
  input logic fa_erase_o,
  input logic fa_chip_o,
  input logic fa_prog_o,
  input logic fa_setup_o,
  input logic fa_check_o
);
  logic busy;
  logic regacc;

  // Operation in progress and register page decode
  assign busy = fa_erase_o | fa_prog_o | fa_setup_o | fa_check_o;
  assign regacc = addr[31:12] == `FEPC_REG_PAGE;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  reg_ack_a: assert property ($rose(req) && regacc |=> ack)
    else $error("register access not answered next cycle");
  flash_ack_a: assert property ($rose(req) && !regacc && !busy |=> !ack ##1 ack)
    else $error("idle flash access wait state wrong");
  fetch_stall_a: assert property (ack && !regacc |-> !$past(busy))
    else $error("flash access answered during an operation");
  sleep_wait_a: assert property (sleep_ok |-> !busy)
    else $error("sleep granted while an operation runs");
  chip_erase_a: assert property (fa_chip_o |-> fa_erase_o)
    else $error("chip strobe without erase strobe");
  chip_noverify_a: assert property ($fell(fa_chip_o) |-> !fa_check_o [*2])
    else $error("verify after chip erase");
  setup_to_prog_a: assert property ($fell(fa_setup_o) |-> fa_prog_o)
    else $error("setup not followed by program pulse");
  prog_after_setup_a: assert property ($rose(fa_prog_o) |-> $past(fa_setup_o))
    else $error("program pulse without setup");
  one_op_a: assert property (fa_prog_o || fa_setup_o |-> !fa_erase_o)
    else $error("erase and program at once");
  check_pulse_a: assert property (fa_check_o |-> !fa_erase_o ##1 !fa_check_o)
    else $error("verify strobe not a single cycle");

  // Main scenarios reached
  cover property ($rose(fa_chip_o));
  cover property (fa_check_o);
  cover property (sleep_ok);
endmodule // fepc_assertions

/* File: tb/flash_erase_program_controller_tb_top.sv */
// Bench top: both controller ends joined, core end driven over AXI4-Lite.
// Assumes shortened hardware erase times; the flash array is two inputs.
`timescale 1ns/1ps
`include "fepc_cfg.svh"
module flash_erase_program_controller_tb_top;
  logic mclk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, fa_verr_i = 1'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] fa_rdata_i = 32'hCAFE_0001;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, fa_addr_o, fa_wdata_o, rd;
  logic fa_erase_o, fa_chip_o, fa_prog_o, fa_setup_o, fa_check_o;
  int err_total = 0, checked = 0, starts = 0, run = 0, srun = 0, plen = 0, slen = 0;
  fepc_if cbus();

  // Clock, 100 ns period
  always #50 mclk_i = ~mclk_i;

  // Core end and controller end, joined by the bus interface
  fepc_host u_fepc_host (.mclk_i, .arst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .bus(cbus));
  fepc_dev #(.HW_CHIP_CYC(200), .HW_SECT_CYC(50)) u_fepc_dev (.mclk_i, .arst_n_i, .bus(cbus),
    .fa_erase_o, .fa_chip_o, .fa_prog_o, .fa_setup_o, .fa_check_o, .fa_addr_o, .fa_wdata_o,
    .fa_rdata_i, .fa_verr_i);
  fepc_assertions u_fepc_assertions (.mclk_i, .arst_n_i, .req(cbus.req), .addr(cbus.addr),
    .ack(cbus.ack), .sleep_ok(cbus.sleep_ok), .fa_erase_o, .fa_chip_o, .fa_prog_o,
    .fa_setup_o, .fa_check_o);

  // Pulse lengths and operation starts on the flash strobes
  always @(posedge mclk_i) begin
    run <= (fa_erase_o | fa_prog_o) ? run + 1 : 0;
    srun <= fa_setup_o ? srun + 1 : 0;
    if (run != 0 && !(fa_erase_o | fa_prog_o)) plen <= run;
    if (srun != 0 && !fa_setup_o) slen <= srun;
    if (run == 0 && (fa_erase_o | fa_prog_o)) starts <= starts + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic hang();
    chk(32'h0, 32'h1);
    give_verdict();
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    if (n == 50) hang();
  endtask

  task automatic axi_rd(input logic [31:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    if (n == 50) hang();
  endtask

  // One controller access through the core end; read data lands in rd
  task automatic dacc(input logic [31:0] a, input logic [31:0] d, input logic we);
    int n;
    axi_wr(`FEPC_H_ADDR, a);
    axi_wr(`FEPC_H_WDATA, d);
    axi_wr(`FEPC_H_CTRL, {30'h0, we, 1'h1});
    for (n = 0; n < 2000; n++) begin
      axi_rd(`FEPC_H_STATUS);
      if (rd[1]) break;
    end
    if (n == 2000) hang();
    axi_wr(`FEPC_H_STATUS, 32'h0000_0002);
    axi_rd(`FEPC_H_RDATA);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    dacc(a, d, 1'h1);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    dacc(a, 32'h0, 1'h0);
    chk(rd, e);
  endtask

  // Flash read stalls until any running operation ends
  task automatic settle();
    dacc(32'h0000_0100, 32'h0, 1'h0);
  endtask

  task automatic t_guard();
    axi_rd(32'h0000_0040);
    chk({30'h0, resp}, 32'h2);
    axi_wr(32'h0000_0040, 32'h0);
    chk({30'h0, resp}, 32'h2);
    rdchk(`FEPC_REG_STATUS, 32'h0);
    rdchk(`FEPC_REG_RANGE, 32'h0);
    wr(`FEPC_REG_GUARD, 32'h0000_0003);
    rdchk(`FEPC_REG_GUARD, 32'h0);
    wr(`FEPC_REG_OPSEL_A, 32'h0000_0055);
    rdchk(`FEPC_REG_OPSEL_A, 32'h0);
    wr(`FEPC_REG_GUARD, 32'h0000_00F1);
    rdchk(`FEPC_REG_GUARD, 32'h1);
    wr(`FEPC_REG_OPSEL_B, 32'h0000_00AA);
    rdchk(`FEPC_REG_OPSEL_B, 32'h0000_00AA);
    $display("t_guard done");
  endtask

  task automatic t_sect();
    wr(`FEPC_REG_ERASE_TYPE, 32'h0000_0010);
    wr(`FEPC_REG_SECT_TIM, 32'h8000_0002);
    wr(`FEPC_REG_OPSEL_A, 32'h0000_0055);
    fa_verr_i <= 1'h1;
    wr(32'h0000_0200, 32'h0);
    settle();
    chk(32'(plen), 32'h200);
    rdchk(`FEPC_REG_STATUS, 32'h0000_0005);
    wr(32'h0000_0400, 32'h0);
    settle();
    chk(32'(starts), 32'h1);
    wr(`FEPC_REG_STATUS, 32'h0000_0005);
    rdchk(`FEPC_REG_STATUS, 32'h0);
    fa_verr_i <= 1'h0;
    $display("t_sect done");
  endtask

  task automatic t_prot();
    wr(`FEPC_REG_RANGE, 32'h5AA5_F001);
    rdchk(`FEPC_REG_RANGE, 32'h0);
    wr(`FEPC_REG_RANGE, 32'h5AA5_F101);
    rdchk(`FEPC_REG_RANGE, 32'h1);
    wr(`FEPC_REG_ERASE_TYPE, 32'h0);
    wr(`FEPC_REG_SECT_TIM, 32'h0);
    wr(32'h0000_0FFC, 32'h0);
    settle();
    chk(32'(starts), 32'h1);
    wr(32'h0000_1000, 32'h0);
    settle();
    chk(32'(starts), 32'h2);
    chk(32'(plen), 32'h32);
    wr(`FEPC_REG_STATUS, 32'h0000_0001);
    wr(`FEPC_REG_OPSEL_A, 32'h0);
    wr(`FEPC_REG_OPSEL_B, 32'h0);
    wr(32'h0000_2000, 32'h0);
    settle();
    chk(32'(starts), 32'h2);
    rdchk(`FEPC_REG_STATUS, 32'h0);
    $display("t_prot done");
  endtask

  task automatic t_prog();
    wr(`FEPC_REG_OPSEL_A, 32'h0000_00AA);
    wr(`FEPC_REG_OPSEL_B, 32'h0000_0055);
    wr(`FEPC_REG_PROG_TIM, 32'h800A_8014);
    wr(32'h0000_2000, 32'h1234_5678);
    settle();
    chk(32'(slen), 32'hA);
    chk(32'(plen), 32'h50);
    chk(fa_wdata_o, 32'h1234_5678);
    chk(32'(starts), 32'h3);
    wr(`FEPC_REG_STATUS, 32'h0000_0001);
    $display("t_prog done");
  endtask

  task automatic t_chip();
    wr(`FEPC_REG_RANGE, 32'h5AA5_F100);
    wr(`FEPC_REG_ERASE_TYPE, 32'h0000_0008);
    wr(`FEPC_REG_CHIP_TIM, 32'h8000_0001);
    wr(`FEPC_REG_OPSEL_A, 32'h0000_0055);
    wr(`FEPC_REG_OPSEL_B, 32'h0000_00AA);
    fa_verr_i <= 1'h1;
    axi_wr(`FEPC_H_SLEEP, 32'h0000_0001);
    wr(32'h0050_1000, 32'h0);
    settle();
    chk(32'(starts), 32'h3);
    wr(32'h0007_FFF0, 32'h0);
    axi_rd(`FEPC_H_STATUS);
    chk(rd & 32'h0000_0004, 32'h0);
    chk(fa_addr_o, 32'h0007_FFF0);
    settle();
    chk({31'h0, fa_chip_o}, 32'h0);
    chk(rd, 32'hCAFE_0001);
    chk(32'(plen), 32'h800);
    rdchk(`FEPC_REG_STATUS, 32'h0000_0001);
    axi_rd(`FEPC_H_STATUS);
    chk(rd & 32'h0000_0004, 32'h0000_0004);
    $display("t_chip done");
  endtask

  // Reset, scenarios, verdict
  initial begin
    repeat (3) @(posedge mclk_i);
    arst_n_i <= 1'h1;
    t_guard();
    t_sect();
    t_prot();
    t_prog();
    t_chip();
    give_verdict();
  end
endmodule // flash_erase_program_controller_tb_top
